/* File: dcf_defines.svh */
// Constants for the deep buffer with programmable status flags.
// Assumes it is included by bare name from the package and design files.
//
// Operation
// [RULE1] Depth 16K to 128K words, 9-bit words
// [RULE2] Separate 9-bit input and output ports
// [RULE3] Store when first enable low, second high
// [RULE4] One word per cycle while enables held
// [RULE5] Read one word per edge, both enables
// [RULE6] Works with shared or independent clocks; the code takes the one clock mclk_in for both ports
// [RULE7] Reads and writes proceed simultaneously
// [RULE8] Empty, full, almost-empty, almost-full outputs
// [RULE9] Offsets settable with one-word resolution
// [RULE10] Default thresholds seven from empty/full
// [RULE11] Empty flags change on read side only
// [RULE12] Full flags change on write side only
// [RULE13] Flags hold at least one cycle
// [RULE14] Active-low output enable releases data outputs
// [RULE15] System drives one enable, expansion other
// [RULE16] One transfer per cycle up to 100 MHz
// [RULE17] Ignore writes when full, reads when empty
// [RULE18] Strap second write enable as load pin
// [RULE19] All four flags are active low
// [RULE20] Reset returns buffer to empty
// [RULE21] Reset clears pointers, flags, restores offsets
// [RULE22] Pointers cross domains gray coded, two stages
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// Word and pointer widths
`define DCF_DATA_W      9
`define DCF_PTR_W       18
// Documented default depth in words
`define DCF_DEPTH_DEF   32'h0000_4000
// Default almost-empty and almost-full offsets
`define DCF_OFS_DEF     18'h0_0007
// Reset values of the flags, active low
`define DCF_EMPTY_RST   1'b0
`define DCF_FULL_RST    1'b1
// Clock figures
`define DCF_CLK_NS      100
`define DCF_CYCLE_MIN_NS 10

`endif

/* File: dcf_pkg.sv */
// Types shared by the buffer core and its pin-level top.
// Assumes dcf_defines.svh is on the include path.
`include "dcf_defines.svh"

package dcf_pkg;

    // Pointer, one bit wider than the largest address
    typedef logic [`DCF_PTR_W-1:0] dcf_ptr_t;
    // One stored word
    typedef logic [`DCF_DATA_W-1:0] dcf_word_t;

    // Offset load sequence: low then high piece of each offset
    typedef enum logic [1:0] {
        DCF_LD_AE_LO = 2'b00,
        DCF_LD_AE_HI = 2'b01,
        DCF_LD_AF_LO = 2'b10,
        DCF_LD_AF_HI = 2'b11
    } dcf_ld_e;

    // Four status flags, all active low
    typedef struct packed {
        logic empty_n;
        logic almost_empty_n;
        logic full_n;
        logic almost_full_n;
    } dcf_flags_s;

    // Whole state of the buffer core
    typedef struct packed {
        dcf_ptr_t   wptr;
        dcf_ptr_t   rptr;
        dcf_ptr_t   wgray;
        dcf_ptr_t   rgray;
        dcf_ptr_t   w_to_r_q1;
        dcf_ptr_t   w_to_r_q2;
        dcf_ptr_t   r_to_w_q1;
        dcf_ptr_t   r_to_w_q2;
        dcf_flags_s flags;
        dcf_word_t  rdata;
    } dcf_core_s;

    // Whole state of the pin-level top
    typedef struct packed {
        logic      armed;
        logic      two_enables;
        dcf_ptr_t  ae_ofs;
        dcf_ptr_t  af_ofs;
        dcf_ld_e   wseq;
        dcf_ld_e   rseq;
        dcf_word_t ld_q;
        logic      show_ld;
    } dcf_top_s;

    // Binary to gray
    function automatic dcf_ptr_t dcf_to_gray(input dcf_ptr_t b);
        return b ^ (b >> 1);
    endfunction : dcf_to_gray

    // Gray to binary
    function automatic dcf_ptr_t dcf_from_gray(input dcf_ptr_t g);
        dcf_ptr_t b;
        b[`DCF_PTR_W-1] = g[`DCF_PTR_W-1];
        for (int i = `DCF_PTR_W-2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : dcf_from_gray

endpackage : dcf_pkg

/* File: dcf_fifo.sv */
// Deep 9-bit buffer: storage core with flags, and the pin-level top.
// Assumes one clock mclk_in for both ports, inputs synchronous to it,
// and an asynchronous active-high reset before first use.
`include "dcf_defines.svh"

// Storage core: valid/ready on both sides, flags from gray pointers
module dcf_fifo_core #(
    parameter int WIDTH = `DCF_DATA_W,
    parameter int DEPTH = 16384
) (
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    // Filling side
    input  wire logic               wr_valid_in,
    input  wire logic [WIDTH-1:0]   wr_data_in,
    output logic                    wr_ready_out,
    // Draining side
    input  wire logic               rd_ready_in,
    output logic                    rd_valid_out,
    output logic [WIDTH-1:0]        rd_data_out,
    // Thresholds
    input  wire dcf_pkg::dcf_ptr_t  ae_ofs_in,
    input  wire dcf_pkg::dcf_ptr_t  af_ofs_in,
    // Flags, active low
    output dcf_pkg::dcf_flags_s     flags_out
);
    localparam int AW = $clog2(DEPTH);
    // Pointer wraps at twice the depth
    localparam dcf_pkg::dcf_ptr_t MASK  = dcf_pkg::dcf_ptr_t'((2 * DEPTH) - 1);
    localparam dcf_pkg::dcf_ptr_t DEP_P = dcf_pkg::dcf_ptr_t'(DEPTH);

    // Refuse shapes the pointers cannot serve
    if (WIDTH != `DCF_DATA_W || (DEPTH != 16384 && DEPTH != 32768
        && DEPTH != 65536 && DEPTH != 131072 && DEPTH != 32))
    begin : g_bad_shape
        $error("dcf_fifo_core: unsupported width or depth");
    end

    dcf_pkg::dcf_core_s st_ff;        // Registered state
    dcf_pkg::dcf_core_s nxt_st;       // Next state
    dcf_pkg::dcf_word_t mem_ff [DEPTH]; // Word storage
    logic               do_wr;        // Store this edge
    logic               do_rd;        // Take this edge
    dcf_pkg::dcf_ptr_t  rcnt;         // Fill seen by the read side
    dcf_pkg::dcf_ptr_t  wcnt;         // Fill seen by the write side
    logic [18:0]        af_lim;       // Fill at which almost-full sets

    // Handshakes come straight from the registered flags
    assign wr_ready_out = st_ff.flags.full_n;
    assign rd_valid_out = st_ff.flags.empty_n;
    assign rd_data_out  = st_ff.rdata;
    assign flags_out    = st_ff.flags;

    // Next-state logic
    always_comb
    begin
        nxt_st = st_ff;
        do_wr  = wr_valid_in && st_ff.flags.full_n;   // [RULE17] [RULE3]
        do_rd  = rd_ready_in && st_ff.flags.empty_n;  // [RULE17] [RULE5]
        // Each side moves on its own, no arbitration
        if (do_wr)
        begin
            nxt_st.wptr = (st_ff.wptr + 1'b1) & MASK; // [RULE4] [RULE7]
        end
        if (do_rd)
        begin
            nxt_st.rptr  = (st_ff.rptr + 1'b1) & MASK; // [RULE7] [RULE16]
            nxt_st.rdata = mem_ff[st_ff.rptr[AW-1:0]];
        end
        nxt_st.wgray = dcf_pkg::dcf_to_gray(nxt_st.wptr); // [RULE22]
        nxt_st.rgray = dcf_pkg::dcf_to_gray(nxt_st.rptr);
        // Two-stage crossing, safe also for separate clocks
        nxt_st.w_to_r_q1 = st_ff.wgray;                  // [RULE22] [RULE6]
        nxt_st.w_to_r_q2 = st_ff.w_to_r_q1;
        nxt_st.r_to_w_q1 = st_ff.rgray;
        nxt_st.r_to_w_q2 = st_ff.r_to_w_q1;
        // Read-side flags use only read pointer and synced write pointer
        rcnt = (dcf_pkg::dcf_from_gray(st_ff.w_to_r_q2) - nxt_st.rptr) & MASK;
        nxt_st.flags.empty_n        = (rcnt != '0);       // [RULE11] [RULE19]
        nxt_st.flags.almost_empty_n = (rcnt > ae_ofs_in); // [RULE8] [RULE9]
        // Write-side flags use only write pointer and synced read pointer
        wcnt   = (nxt_st.wptr - dcf_pkg::dcf_from_gray(st_ff.r_to_w_q2)) & MASK;
        af_lim = {1'b0, DEP_P} - {1'b0, af_ofs_in};
        nxt_st.flags.full_n        = (wcnt != DEP_P);                        // [RULE12]
        nxt_st.flags.almost_full_n = af_ofs_in > DEP_P ? 1'b0
                                   : ({1'b0, wcnt} < af_lim);                // [RULE8]
    end

    // State register; flags registered so each holds a full cycle
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_ff                      <= '0;                 // [RULE21] [RULE20]
            st_ff.flags.empty_n        <= `DCF_EMPTY_RST;
            st_ff.flags.almost_empty_n <= `DCF_EMPTY_RST;
            st_ff.flags.full_n         <= `DCF_FULL_RST;
            st_ff.flags.almost_full_n  <= `DCF_FULL_RST;
        end
        else
        begin
            st_ff <= nxt_st;                                  // [RULE13]
        end
    end

    // Storage has no reset; pointers alone define content
    always_ff @(posedge mclk_in)
    begin
        if (do_wr)
        begin
            mem_ff[st_ff.wptr[AW-1:0]] <= wr_data_in;         // [RULE1]
        end
    end

endmodule : dcf_fifo_core

// Pin-level top: enables, offset load mode, output enable
module dcf_fifo_top #(
    parameter int DEPTH = 16384
) (
    // Clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    rst_in,
    // Write port
    input  wire logic [`DCF_DATA_W-1:0]  data_in,
    input  wire logic                    primary_write_enable_n_in,
    input  wire logic                    secondary_write_enable_or_offset_load_in,
    // Read port
    input  wire logic                    first_read_enable_n_in,
    input  wire logic                    second_read_enable_n_in,
    input  wire logic                    output_enable_n_in,
    output logic [`DCF_DATA_W-1:0]       data_out,
    output logic                         data_oe_out,
    // Status flags, active low
    output logic                         empty_flag_n_out,
    output logic                         almost_empty_flag_n_out,
    output logic                         full_flag_n_out,
    output logic                         almost_full_flag_n_out
);
    dcf_pkg::dcf_top_s   st_ff;       // Registered state
    dcf_pkg::dcf_top_s   nxt_st;      // Next state
    dcf_pkg::dcf_flags_s flags;       // Core flags
    dcf_pkg::dcf_word_t  core_q;      // Core read data
    logic                ld_mode;     // Load pin held low in load config
    logic                wr_req;      // Data store request
    logic                rd_req;      // Data take request
    logic                rd_both;     // Both read enables low

    // Load pin meaning only once armed in the one-enable config
    assign ld_mode = st_ff.armed && !st_ff.two_enables
                   && !secondary_write_enable_or_offset_load_in;  // [RULE18]
    assign rd_both = !first_read_enable_n_in && !second_read_enable_n_in; // [RULE5] [RULE15]
    assign wr_req  = st_ff.armed && !primary_write_enable_n_in
                   && secondary_write_enable_or_offset_load_in;   // [RULE3] [RULE15]
    assign rd_req  = st_ff.armed && rd_both && !ld_mode;

    // Buffer core
    dcf_fifo_core #(
        .WIDTH (`DCF_DATA_W),
        .DEPTH (DEPTH)
    ) u_core (
        .mclk_in      (mclk_in),
        .rst_in       (rst_in),
        .wr_valid_in  (wr_req),
        .wr_data_in   (data_in),
        .wr_ready_out (),
        .rd_ready_in  (rd_req),
        .rd_valid_out (),
        .rd_data_out  (core_q),
        .ae_ofs_in    (st_ff.ae_ofs),
        .af_ofs_in    (st_ff.af_ofs),
        .flags_out    (flags)
    );

    // Next-state logic: strap capture and offset load/read-back
    always_comb
    begin
        nxt_st = st_ff;
        // Strap caught on the first edge after reset release
        if (!st_ff.armed)
        begin
            nxt_st.armed       = 1'b1;
            nxt_st.two_enables = secondary_write_enable_or_offset_load_in; // [RULE18]
        end
        // Offset write, low piece then high piece, almost-empty first
        if (ld_mode && !primary_write_enable_n_in)
        begin
            nxt_st.wseq = dcf_pkg::dcf_ld_e'(st_ff.wseq + 2'h1);
            unique case (st_ff.wseq)
                dcf_pkg::DCF_LD_AE_LO: nxt_st.ae_ofs[8:0]   = data_in; // [RULE9]
                dcf_pkg::DCF_LD_AE_HI: nxt_st.ae_ofs[17:9]  = data_in;
                dcf_pkg::DCF_LD_AF_LO: nxt_st.af_ofs[8:0]   = data_in;
                dcf_pkg::DCF_LD_AF_HI: nxt_st.af_ofs[17:9]  = data_in;
            endcase
        end
        // Offset read-back in the same order
        if (ld_mode && rd_both)
        begin
            nxt_st.rseq    = dcf_pkg::dcf_ld_e'(st_ff.rseq + 2'h1);
            nxt_st.show_ld = 1'b1;
            unique case (st_ff.rseq)
                dcf_pkg::DCF_LD_AE_LO: nxt_st.ld_q = st_ff.ae_ofs[8:0];
                dcf_pkg::DCF_LD_AE_HI: nxt_st.ld_q = st_ff.ae_ofs[17:9];
                dcf_pkg::DCF_LD_AF_LO: nxt_st.ld_q = st_ff.af_ofs[8:0];
                dcf_pkg::DCF_LD_AF_HI: nxt_st.ld_q = st_ff.af_ofs[17:9];
            endcase
        end
        else if (rd_req && flags.empty_n)
        begin
            nxt_st.show_ld = 1'b0;   // Data read takes the outputs back
        end
    end

    // State register; offsets return to their defaults
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_ff             <= '0;
            st_ff.two_enables <= 1'b1;
            st_ff.ae_ofs      <= `DCF_OFS_DEF;   // [RULE10] [RULE21]
            st_ff.af_ofs      <= `DCF_OFS_DEF;   // [RULE10]
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs; released data lines show an idle driver
    assign data_out    = st_ff.show_ld ? st_ff.ld_q : core_q;  // [RULE2]
    assign data_oe_out = !output_enable_n_in;                  // [RULE14]
    assign empty_flag_n_out        = flags.empty_n;            // [RULE19]
    assign almost_empty_flag_n_out = flags.almost_empty_n;
    assign full_flag_n_out         = flags.full_n;
    assign almost_full_flag_n_out  = flags.almost_full_n;

endmodule : dcf_fifo_top

/* File: dcf_fifo_sva.sv */
// Checker for the buffer top: flag and output relations at the pins.
// Assumes one clock and an async active-high reset; bound below.
`include "dcf_defines.svh"

module dcf_fifo_sva #(
    parameter int DEPTH = 16384
) (
    // Clock and reset
    input wire logic                   mclk_in,
    input wire logic                   rst_in,
    // Write port
    input wire logic [`DCF_DATA_W-1:0] data_in,
    input wire logic                   primary_write_enable_n_in,
    input wire logic                   secondary_write_enable_or_offset_load_in,
    // Read port
    input wire logic                   first_read_enable_n_in,
    input wire logic                   second_read_enable_n_in,
    input wire logic                   output_enable_n_in,
    input wire logic [`DCF_DATA_W-1:0] data_out,
    input wire logic                   data_oe_out,
    // Flags, active low
    input wire logic                   empty_flag_n_out,
    input wire logic                   almost_empty_flag_n_out,
    input wire logic                   full_flag_n_out,
    input wire logic                   almost_full_flag_n_out
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    // Reset forces empty, clears full; must hold while reset is high
    property p_rst;
        disable iff (1'h0) rst_in |-> {empty_flag_n_out, almost_empty_flag_n_out,
            full_flag_n_out, almost_full_flag_n_out} == 4'h3;
    endproperty
    a_rst: assert property (p_rst) else $error("flags wrong in reset");
    // Output enable follows its pin at once
    property p_oe;
        data_oe_out != output_enable_n_in;
    endproperty
    a_oe: assert property (p_oe) else $error("output enable wrong");
    // A read while empty leaves the output word alone
    property p_refuse;
        !empty_flag_n_out && !first_read_enable_n_in && !second_read_enable_n_in
            && secondary_write_enable_or_offset_load_in |=> $stable(data_out);
    endproperty
    a_refuse: assert property (p_refuse) else $error("read taken while empty");
    // Empty is only entered right after a read request
    property p_efall;
        $fell(empty_flag_n_out) |-> !$past(first_read_enable_n_in)
            && !$past(second_read_enable_n_in);
    endproperty
    a_efall: assert property (p_efall) else $error("empty without read");
    // Full is only entered right after a write request
    property p_ffall;
        $fell(full_flag_n_out) |-> !$past(primary_write_enable_n_in)
            && $past(secondary_write_enable_or_offset_load_in);
    endproperty
    a_ffall: assert property (p_ffall) else $error("full without write");
    // Empty with no writes for four cycles stays empty
    property p_stay;
        (!empty_flag_n_out && primary_write_enable_n_in) [*4] |=> !empty_flag_n_out;
    endproperty
    a_stay: assert property (p_stay) else $error("empty left without write");
    // Empty implies almost empty
    property p_ae;
        !empty_flag_n_out |-> !almost_empty_flag_n_out;
    endproperty
    a_ae: assert property (p_ae) else $error("almost empty missing");
    // Full implies almost full
    property p_af;
        !full_flag_n_out |-> !almost_full_flag_n_out;
    endproperty
    a_af: assert property (p_af) else $error("almost full missing");
endmodule : dcf_fifo_sva

bind dcf_fifo_top dcf_fifo_sva #(.DEPTH(DEPTH)) u_sva (
    .mclk_in(mclk_in), .rst_in(rst_in), .data_in(data_in),
    .primary_write_enable_n_in(primary_write_enable_n_in),
    .secondary_write_enable_or_offset_load_in(secondary_write_enable_or_offset_load_in),
    .first_read_enable_n_in(first_read_enable_n_in),
    .second_read_enable_n_in(second_read_enable_n_in),
    .output_enable_n_in(output_enable_n_in), .data_out(data_out), .data_oe_out(data_oe_out),
    .empty_flag_n_out(empty_flag_n_out), .almost_empty_flag_n_out(almost_empty_flag_n_out),
    .full_flag_n_out(full_flag_n_out), .almost_full_flag_n_out(almost_full_flag_n_out)
);

/* File: dcf_sys_model.sv */
// System logic model: drives the port enables and mirrors accepted words.
// Assumes requests change at the falling edge.
module dcf_sys_model (
    // Clock, reset, bench requests
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       wr_go_in,
    input  wire logic       rd_go_in,
    input  wire logic       rd_sel_in,
    input  wire logic       strap_in,
    input  wire logic [8:0] wdata_in,
    // Flags seen
    input  wire logic       full_n_in,
    input  wire logic       empty_n_in,
    // Pins and reference
    output logic            pwe_n_out,
    output logic            swe_out,
    output logic            re1_n_out,
    output logic            re2_n_out,
    output logic [8:0]      d_out,
    output logic            rd_hit_out,
    output logic [8:0]      exp_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [8:0] ref_q[$]; // Accepted words, oldest first

    // Own enables for control; second read enable from expansion select, second write enable from the strap
    assign pwe_n_out = !wr_go_in;
    assign swe_out   = strap_in;
    assign re1_n_out = !rd_go_in;
    assign re2_n_out = !rd_sel_in;
    assign d_out     = wdata_in;

    // Pop before push so a word is never read in its own store cycle
    always @(posedge mclk_in or posedge rst_in)
    begin
        rd_hit_out = 1'h0;
        if (rst_in)
            ref_q.delete();
        else
        begin
            if (!re1_n_out && !re2_n_out && swe_out && empty_n_in && ref_q.size() > 0)
            begin
                exp_out = ref_q.pop_front();
                rd_hit_out = 1'h1;
            end
            if (!pwe_n_out && swe_out && full_n_in)
                ref_q.push_back(d_out);
        end
    end
endmodule : dcf_sys_model

/* File: testbench.sv */
// Bench for the buffer top: fill, drain, mixed traffic, offset load.
// Assumes design, checker and system model are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int DEPTH = 32; // Short depth keeps the run brief

    logic       mclk_in = 1'h0;
    logic       rst_in = 1'h0;
    logic       wr_go = 1'h0, rd_go = 1'h0, rd_sel = 1'h1, strap = 1'h1, oe_n = 1'h0;
    logic [8:0] wdata = 9'h000, d_pin, q_pin, exp_w;
    logic       pwe_n, swe, re1_n, re2_n, rd_hit, oe, ef_n, aef_n, ff_n, aff_n;
    logic [31:0] lfsr = 32'h0000_50c4;
    int         errors = 0, total_checks = 0;

    always #50 mclk_in = ~mclk_in; // 10 MHz

    dcf_fifo_top #(.DEPTH(DEPTH)) DUT (
        .mclk_in(mclk_in), .rst_in(rst_in), .data_in(d_pin),
        .primary_write_enable_n_in(pwe_n), .secondary_write_enable_or_offset_load_in(swe),
        .first_read_enable_n_in(re1_n), .second_read_enable_n_in(re2_n),
        .output_enable_n_in(oe_n), .data_out(q_pin), .data_oe_out(oe),
        .empty_flag_n_out(ef_n), .almost_empty_flag_n_out(aef_n),
        .full_flag_n_out(ff_n), .almost_full_flag_n_out(aff_n)
    );
    dcf_sys_model u_sys (
        .mclk_in(mclk_in), .rst_in(rst_in), .wr_go_in(wr_go), .rd_go_in(rd_go),
        .rd_sel_in(rd_sel), .strap_in(strap), .wdata_in(wdata), .full_n_in(ff_n),
        .empty_n_in(ef_n), .pwe_n_out(pwe_n), .swe_out(swe), .re1_n_out(re1_n),
        .re2_n_out(re2_n), .d_out(d_pin), .rd_hit_out(rd_hit), .exp_out(exp_w)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Expected {empty, almost empty, full, almost full} at default offsets
    function automatic logic [3:0] exp_flags(input int fill);
        return {fill > 0, fill > 7, fill < DEPTH, fill < DEPTH - 7};
    endfunction : exp_flags

    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One cycle; compare any word the model saw leave
    task automatic tick();
        @(negedge mclk_in);
        if (rd_hit)
            check("data_out", q_pin, exp_w);
    endtask : tick

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        errors++;
        test_done();
    end

    initial
    begin
        logic [3:0] fl;
        logic [8:0] pc [4];
        #1 rst_in = 1'h1;
        repeat (8) @(negedge mclk_in);
        check("rst_flags", {ef_n, aef_n, ff_n, aff_n}, 9'h003);
        rst_in = 1'h0;
        repeat (2) tick();
        oe_n = 1'h1;
        #1 check("data_oe", oe, 9'h000);
        oe_n = 1'h0;
        #1 check("data_oe", oe, 9'h001);
        // Back-to-back fill, last word refused
        for (int i = 0; i <= DEPTH; i++)
        begin
            lfsr = lfsr_next(lfsr);
            wdata = lfsr[8:0];
            wr_go = 1'h1;
            tick();
            fl = exp_flags((i < DEPTH) ? i + 1 : DEPTH);
            check("full_side", {ff_n, aff_n}, fl[1:0]);
        end
        wr_go = 1'h0;
        repeat (4) tick();
        check("empty_side", {ef_n, aef_n}, 9'h003);
        // Drain, last read refused
        for (int i = 0; i <= DEPTH; i++)
        begin
            rd_go = 1'h1;
            tick();
            fl = exp_flags((i < DEPTH) ? DEPTH - 1 - i : 0);
            check("empty_side", {ef_n, aef_n}, fl[3:2]);
        end
        check("data_out", q_pin, exp_w);
        rd_go = 1'h0;
        repeat (4) tick();
        check("full_side", {ff_n, aff_n}, 9'h003);
        // Mixed traffic on both ports at once
        repeat (400)
        begin
            lfsr = lfsr_next(lfsr);
            wdata = lfsr[8:0];
            wr_go = lfsr[9] | lfsr[10];
            rd_go = lfsr[11];
            rd_sel = lfsr[12] | lfsr[13];
            tick();
        end
        {wr_go, rd_go, rd_sel} = 3'h1;
        // Strap for offset load, write four pieces, read them back
        rst_in = 1'h1;
        strap = 1'h0;
        repeat (2) tick();
        rst_in = 1'h0;
        repeat (2) tick();
        for (int i = 0; i < 4; i++)
        begin
            lfsr = lfsr_next(lfsr);
            pc[i] = lfsr[8:0];
            wdata = pc[i];
            wr_go = 1'h1;
            tick();
        end
        wr_go = 1'h0;
        for (int i = 0; i < 4; i++)
        begin
            rd_go = 1'h1;
            tick();
            check("offset", q_pin, pc[i]);
        end
        test_done();
    end
endmodule : testbench
